// >>> hw/addr_map_pkg.sv
// Package with the system address map constants and carrier types
package addr_map_pkg;
   localparam int unsigned ADDR_W = 32;
   localparam logic [31:0] DRAM_BASE = 32'h0000_0000;
   localparam logic [31:0] DRAM_SIZE = 32'h4000_0000;
   localparam logic [31:0] FAB0_BASE = 32'h4000_0000;
   localparam logic [31:0] FAB0_SIZE = 32'h4000_0000;
   localparam logic [31:0] FAB1_BASE = 32'h8000_0000;
   localparam logic [31:0] FAB1_SIZE = 32'h4000_0000;
   localparam logic [31:0] IO_GROUP_BASE = 32'he000_0000;
   localparam logic [31:0] IO_GROUP_SIZE = 32'h1000_0000;
   localparam logic [31:0] RSV0_BASE = 32'hf000_0000;
   localparam logic [31:0] RSV0_SIZE = 32'h0800_0000;
   localparam logic [31:0] APB_BASE = 32'hf800_0000;
   localparam logic [31:0] APB_SIZE = 32'h0200_0000;
   localparam logic [31:0] RSV1_BASE = 32'hfa00_0000;
   localparam logic [31:0] RSV1_SIZE = 32'h0200_0000;
   localparam logic [31:0] QSPI_BASE = 32'hfc00_0000;
   localparam logic [31:0] QSPI_SIZE = 32'h03fc_0000;
   localparam logic [31:0] QSPI_BACKED = 32'h0200_0000;
   localparam logic [31:0] HIRAM_BASE = 32'hfffc_0000;
   localparam logic [31:0] HIRAM_SIZE = 32'h0004_0000;

   typedef enum logic [3:0] {
      TGT_DRAM = 4'h0,
      TGT_FAB0 = 4'h1,
      TGT_FAB1 = 4'h2,
      TGT_IO_GROUP = 4'h3,
      TGT_APB = 4'h4,
      TGT_QSPI = 4'h5,
      TGT_HIRAM = 4'h6,
      TGT_ERR = 4'h7
   } target_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } req_t;

   typedef struct packed {
      logic valid;
      logic write;
      target_t target;
      logic decode_err;
      logic [31:0] offset;
   } route_t;
endpackage

// >>> hw/region_match.sv
// Single region comparator: hit flag and offset within the region
`timescale 1ns/100ps
module region_match
   import addr_map_pkg::*;
#(
   parameter logic [31:0] BASE = 32'h0000_0000,
   parameter logic [31:0] SIZE = 32'h0000_1000
) (
   input wire logic [31:0] addr,
   output logic hit,
   output logic [31:0] offset
);
   // Subtract first so a region may end at the top of the space
   always_comb begin
      offset = addr - BASE;
      hit = (addr >= BASE) && (offset < SIZE);
   end
endmodule

// >>> hw/system_address_decoder.sv
// Top-level system address decoder routing each access to one region
// Contract
// - Flat 4 GB, 32-bit byte address space; each access hits at most one region
// - First 1,024 MB from zero go to DRAM and on-chip RAM
// - 1,024 MB from 0x4000_0000 go to fabric AXI slave port 0
// - 1,024 MB from 0x8000_0000 go to fabric AXI slave port 1
// - 32 MB from 0xF800_0000 go to APB control and status registers
// - From 0xFC00_0000 quad-SPI linear window; only lower 32 MB backed
// - Top 256 KB reach on-chip RAM when mapped high
`timescale 1ns/100ps
module system_address_decoder
   import addr_map_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [31:0] req_addr,
   input wire logic on_chip_ram_high,
   output route_t route_q
);
   localparam int NREG = 9;
   localparam logic [31:0] BASES [NREG] = '{DRAM_BASE, FAB0_BASE,
      FAB1_BASE, IO_GROUP_BASE, RSV0_BASE, APB_BASE, RSV1_BASE, QSPI_BASE,
      HIRAM_BASE};
   localparam logic [31:0] SIZES [NREG] = '{DRAM_SIZE, FAB0_SIZE,
      FAB1_SIZE, IO_GROUP_SIZE, RSV0_SIZE, APB_SIZE, RSV1_SIZE, QSPI_SIZE,
      HIRAM_SIZE};

   logic [NREG-1:0] hit;
   logic [31:0] offs [NREG];
   route_t route_d;

   // Comparator bank, one per map entry
   genvar g;
   generate
      for (g = 0; g < NREG; g++) begin : g_rm
         region_match #(.BASE(BASES[g]), .SIZE(SIZES[g])) u_rm (
            .addr(req_addr),
            .hit(hit[g]),
            .offset(offs[g])
         );
      end
   endgenerate

   // Holes (0xc000_0000 to 0xdfff_ffff) also fall to the error target
   always_comb begin
      route_d = '0;
      route_d.valid = req_valid;
      route_d.write = req_write;
      route_d.target = TGT_ERR;
      route_d.decode_err = 1'b1;
      route_d.offset = req_addr;
      if (hit[0]) begin
         route_d.target = TGT_DRAM;
         route_d.decode_err = 1'b0;
         route_d.offset = offs[0];
      end else if (hit[1]) begin
         route_d.target = TGT_FAB0;
         route_d.decode_err = 1'b0;
         route_d.offset = offs[1];
      end else if (hit[2]) begin
         route_d.target = TGT_FAB1;
         route_d.decode_err = 1'b0;
         route_d.offset = offs[2];
      end else if (hit[3]) begin
         route_d.target = TGT_IO_GROUP;
         route_d.decode_err = 1'b0;
         route_d.offset = offs[3];
      end else if (hit[5]) begin
         route_d.target = TGT_APB;
         route_d.decode_err = 1'b0;
         route_d.offset = offs[5];
      end else if (hit[7] && offs[7] < QSPI_BACKED) begin
         // Unbacked upper part of the flash window errors out
         route_d.target = TGT_QSPI;
         route_d.decode_err = 1'b0;
         route_d.offset = offs[7];
      end else if (hit[8] && on_chip_ram_high) begin
         route_d.target = TGT_HIRAM;
         route_d.decode_err = 1'b0;
         route_d.offset = offs[8];
      end
      if (!req_valid) begin
         route_d = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         route_q <= '0;
      end else begin
         route_q <= route_d;
      end
   end

   // Assertion helpers: the access seen one edge back, lined up with
   // route_q; flops rather than sampled functions so reset clears them
   logic seen_v_d;
   logic seen_w_d;
   logic seen_hi_d;
   logic [31:0] seen_a_d;
   logic seen_v_q;
   logic seen_w_q;
   logic seen_hi_q;
   logic [31:0] seen_a_q;

   always_comb begin
      seen_v_d = req_valid;
      seen_w_d = req_write;
      seen_hi_d = on_chip_ram_high;
      seen_a_d = req_addr;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         seen_v_q <= 1'b0;
         seen_w_q <= 1'b0;
         seen_hi_q <= 1'b0;
         seen_a_q <= 32'h0000_0000;
      end else begin
         seen_v_q <= seen_v_d;
         seen_w_q <= seen_w_d;
         seen_hi_q <= seen_hi_d;
         seen_a_q <= seen_a_d;
      end
   end

   // Window test shared by the route checks; base-relative so no overflow
   function automatic logic in_win(input logic [31:0] a,
      input logic [31:0] base, input logic [31:0] size);
      logic [31:0] rel;
      rel = a - base;
      return (a >= base) && (rel < size);
   endfunction

   a_one_region: assert property (
      @(posedge clk) disable iff (!rst_b)
      route_q.valid |-> (route_q.decode_err == (route_q.target == TGT_ERR)))
      else $error("error flag and target disagree");

   a_reset_clear: assert property (
      @(posedge clk)
      !rst_b |=> route_q == '0)
      else $error("route not cleared by reset");

   a_idle_zero: assert property (
      @(posedge clk) disable iff (!rst_b)
      !req_valid |=> route_q == '0)
      else $error("idle cycle left a route");

   a_write_pass: assert property (
      @(posedge clk) disable iff (!rst_b)
      seen_v_q |-> route_q.valid && route_q.write == seen_w_q)
      else $error("access kind not passed through");

   a_hole_err: assert property (
      @(posedge clk) disable iff (!rst_b)
      seen_v_q && seen_a_q[31:29] == 3'h6 |->
      route_q.target == TGT_ERR && route_q.offset == seen_a_q)
      else $error("unmapped hole not errored");

   a_dram_route: assert property (
      @(posedge clk) disable iff (!rst_b)
      req_valid && req_addr[31:30] == 2'h0 |=> route_q.target == TGT_DRAM)
      else $error("low address not routed to dram");

   a_dram_offset: assert property (
      @(posedge clk) disable iff (!rst_b)
      seen_v_q && in_win(seen_a_q, DRAM_BASE, DRAM_SIZE) |->
      route_q.offset == seen_a_q - DRAM_BASE)
      else $error("dram offset wrong");

   a_fab0_route: assert property (
      @(posedge clk) disable iff (!rst_b)
      req_valid && req_addr[31:30] == 2'h1 |=>
      route_q.target == TGT_FAB0 && route_q.offset == {2'h0, seen_a_q[29:0]})
      else $error("fabric port 0 misrouted");

   a_fab1_route: assert property (
      @(posedge clk) disable iff (!rst_b)
      req_valid && req_addr[31:30] == 2'h2 |=> route_q.target == TGT_FAB1)
      else $error("fabric port 1 misrouted");

   a_fab1_offset: assert property (
      @(posedge clk) disable iff (!rst_b)
      seen_v_q && in_win(seen_a_q, FAB1_BASE, FAB1_SIZE) |->
      route_q.offset == seen_a_q - FAB1_BASE)
      else $error("fabric port 1 offset wrong");

   a_apb_route: assert property (
      @(posedge clk) disable iff (!rst_b)
      req_valid && req_addr[31:25] == 7'h7c |=> route_q.target == TGT_APB)
      else $error("register window misrouted");

   a_apb_offset: assert property (
      @(posedge clk) disable iff (!rst_b)
      seen_v_q && in_win(seen_a_q, APB_BASE, APB_SIZE) |->
      route_q.offset == seen_a_q - APB_BASE)
      else $error("register window offset wrong");

   a_qspi_route: assert property (
      @(posedge clk) disable iff (!rst_b)
      route_q.target == TGT_QSPI |-> seen_v_q && seen_a_q[31:25] == 7'h7e)
      else $error("flash target outside backed window");

   a_qspi_offset: assert property (
      @(posedge clk) disable iff (!rst_b)
      seen_v_q && in_win(seen_a_q, QSPI_BASE, QSPI_BACKED) |->
      route_q.target == TGT_QSPI && route_q.offset == seen_a_q - QSPI_BASE)
      else $error("backed flash access misrouted");

   // Unbacked flash space must not reach the flash controller
   a_qspi_unbacked: assert property (
      @(posedge clk) disable iff (!rst_b)
      seen_v_q && seen_a_q >= QSPI_BASE + QSPI_BACKED &&
      seen_a_q < HIRAM_BASE |-> route_q.decode_err)
      else $error("unbacked flash access not errored");

   a_hiram_route: assert property (
      @(posedge clk) disable iff (!rst_b)
      seen_v_q && seen_a_q[31:18] == 14'h3fff |->
      route_q.target == (seen_hi_q ? TGT_HIRAM : TGT_ERR))
      else $error("high ram routing wrong");

   a_reserved_err: assert property (
      @(posedge clk) disable iff (!rst_b)
      req_valid && (req_addr[31:27] == 5'h1e || req_addr[31:25] == 7'h7d)
      |=> route_q.decode_err && route_q.valid)
      else $error("reserved window did not error");

   a_io_route: assert property (
      @(posedge clk) disable iff (!rst_b)
      seen_v_q && in_win(seen_a_q, IO_GROUP_BASE, IO_GROUP_SIZE) |->
      route_q.target == TGT_IO_GROUP &&
      route_q.offset == seen_a_q - IO_GROUP_BASE)
      else $error("io group misrouted");
endmodule

// >>> test/access_master.sv
// Partner model: interconnect master issuing accesses
`timescale 1ns/100ps
module access_master (
   input wire logic clk,
   output logic req_valid,
   output logic req_write,
   output logic [31:0] req_addr
);
   initial begin
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 32'h0000_0000;
   end
   // One access per cycle; the decoder has no stall to wait on
   task automatic send(input logic [31:0] a, input logic w);
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
   endtask
   // A released address shows its inverse, never a stale value
   task automatic idle();
      @(posedge clk);
      req_valid <= 1'b0;
      req_addr <= ~req_addr;
   endtask
endmodule

// >>> test/system_address_decoder_tb.sv
// Self-checking bench for the system address decoder
`timescale 1ns/100ps
module system_address_decoder_tb;
   import addr_map_pkg::*;
   logic clk, rst_b, req_valid, req_write, high;
   logic [31:0] req_addr;
   route_t route_q;
   int err_count = 0;
   int check_count = 0;
   access_master access_master_inst (.clk(clk), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr));
   system_address_decoder system_address_decoder_inst (.clk(clk),
      .rst_b(rst_b), .req_valid(req_valid), .req_write(req_write),
      .req_addr(req_addr), .on_chip_ram_high(high), .route_q(route_q));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic close_out();
      if (err_count == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic check(input route_t seen, input route_t exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic route_t hit(input logic [31:0] a, input target_t t,
      input logic [31:0] base, input logic w);
      return '{1'b1, w, t, t == TGT_ERR, a - base};
   endfunction
   task automatic probe(input logic [31:0] a, input target_t t,
      input logic [31:0] base);
      access_master_inst.send(a, 1'b0);
      @(posedge clk);
      #1 check(route_q, hit(a, t, base, 1'b0));
   endtask
   task automatic t_reset();
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      #1 check(route_q, '0);
   endtask
   task automatic t_map();
      probe(32'h3fff_ffff, TGT_DRAM, DRAM_BASE);
      probe(32'h4000_0000, TGT_FAB0, FAB0_BASE);
      probe(32'hbfff_ffff, TGT_FAB1, FAB1_BASE);
      probe(32'hc000_0000, TGT_ERR, 32'h0);
      probe(32'hefff_ffff, TGT_IO_GROUP, IO_GROUP_BASE);
      probe(32'hf000_0000, TGT_ERR, 32'h0);
      probe(32'hf9ff_ffff, TGT_APB, APB_BASE);
      probe(32'hfa00_0000, TGT_ERR, 32'h0);
      probe(32'hfdff_ffff, TGT_QSPI, QSPI_BASE);
      probe(32'hfe00_0000, TGT_ERR, 32'h0);
   endtask
   task automatic t_high();
      probe(32'hfffc_0000, TGT_ERR, 32'h0);
      @(posedge clk);
      high <= 1'b1;
      probe(32'hfffc_0000, TGT_HIRAM, HIRAM_BASE);
      probe(32'hffff_ffff, TGT_HIRAM, HIRAM_BASE);
      probe(32'hfffb_ffff, TGT_ERR, 32'h0);
   endtask
   // Back to back, then idle: each cycle routes only its own access
   task automatic t_flow();
      access_master_inst.send(32'h4000_0010, 1'b1);
      access_master_inst.send(32'h0000_0000, 1'b0);
      #1 check(route_q, hit(32'h10, TGT_FAB0, 32'h0, 1'b1));
      access_master_inst.idle();
      #1 check(route_q, hit(32'h0, TGT_DRAM, 32'h0, 1'b0));
      @(posedge clk);
      #1 check(route_q, '0);
   endtask
   initial begin
      rst_b = 1'b0;
      high = 1'b0;
      t_reset();
      t_map();
      t_high();
      t_flow();
      close_out();
   end
   initial begin
      repeat (2000) @(posedge clk);
      err_count++;
      close_out();
   end
endmodule
